// >>> pkg/ars_pkg.sv
package ars_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RESULT_W = 10;
  localparam int SEL_W = 3;
  localparam int NUM_SRC = 8;
  localparam int IRQ_W = 2;
  // Result bits that spill past one byte
  localparam int SPILL_W = RESULT_W - DATA_W;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;

  // ==========================================================================
  // Field positions
  localparam int CTLA_EN_BIT = 7;
  localparam int CTLA_START_BIT = 6;
  localparam int CTLA_ATE_BIT = 5;
  localparam int CTLA_DONE_BIT = 4;
  localparam int MUX_LADJ_BIT = 5;
  localparam int CTLB_SEL_LSB = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [RESULT_W-1:0] RESET_RESULT = 10'h000;
  localparam logic [IRQ_W-1:0] RESET_IRQ = 2'h0;

  // ==========================================================================
  // Trigger source codes
  typedef enum logic [SEL_W-1:0] {
    TRIG_FREE_RUN = 3'h0,
    TRIG_ANALOG_CMP = 3'h1,
    TRIG_EXT_IRQ0 = 3'h2,
    TRIG_TMR0_CMP = 3'h3,
    TRIG_TMR0_OVF = 3'h4,
    TRIG_TMR_CMP_B = 3'h5,
    TRIG_TMR1_OVF = 3'h6,
    TRIG_TMR1_CAPT = 3'h7
  } ars_trig_src_type;

  // ==========================================================================
  // Result read lock
  typedef enum logic [1:0] {
    LOCK_OPEN = 2'b01,
    LOCK_HELD = 2'b10
  } ars_lock_type;

endpackage : ars_pkg

// >>> src/ars_trig.sv
module ars_trig #(
  parameter int NUM_SRC = ars_pkg::NUM_SRC,
  parameter int SEL_W = ars_pkg::SEL_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Sources, index 0 is the conversion done flag
  input wire logic [NUM_SRC-1:0] flags_in,
  input wire logic done_pulse_in,
  // Control
  input wire logic [SEL_W-1:0] sel_in,
  input wire logic auto_en_in,
  input wire logic conv_en_in,
  // Trigger
  output logic trig_out
);

  logic prev_level;

  wire sel_level = flags_in[sel_in];
  wire free_run = (sel_in == ars_pkg::TRIG_FREE_RUN);
  // Free running restarts on a completion while not busy, never on a switch to it
  wire edge_seen = free_run ? done_pulse_in : (sel_level & ~prev_level);

  assign trig_out = auto_en_in & conv_en_in & edge_seen;

  // Tracks the selected level, so a switch from a clear source to a set one, other than free running, looks like an edge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= sel_level;
    end
  end

endmodule : ars_trig

// >>> src/ars_top.sv
module ars_top (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Register port
  input wire logic [ars_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [ars_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [ars_pkg::DATA_W-1:0] REG_RDATA_OUT,
  // Converter core
  input wire logic CONV_DONE_IN,
  input wire logic [ars_pkg::RESULT_W-1:0] CONV_RESULT_IN,
  output logic CONV_START_OUT,
  output logic CONV_EN_OUT,
  // Peripheral flags, source codes 1 to 7
  input wire logic [ars_pkg::NUM_SRC-1:1] TRIG_FLAGS_IN,
  // Interrupt
  output logic IRQ_OUT
);

  // ==========================================================================
  // State
  logic converter_en;
  logic auto_trigger_en;
  logic busy;
  logic conversion_done_flag;
  logic left_adjust_ctl;
  logic [ars_pkg::SEL_W-1:0] trigger_source_sel;
  logic [ars_pkg::RESULT_W-1:0] result;
  ars_pkg::ars_lock_type lock_state;
  ars_pkg::ars_lock_type next_lock_state;
  logic [ars_pkg::IRQ_W-1:0] irq_status;
  logic [ars_pkg::IRQ_W-1:0] irq_mask;
  logic [ars_pkg::DATA_W-1:0] rdata;
  logic conv_start;
  logic trig_hit;

  // ==========================================================================
  // Address decode
  wire hit_low = (REG_ADDR_IN == ars_pkg::OFS_RESULT_LOW);
  wire hit_high = (REG_ADDR_IN == ars_pkg::OFS_RESULT_HIGH);
  wire hit_ctla = (REG_ADDR_IN == ars_pkg::OFS_CONTROL_A);
  wire hit_mux = (REG_ADDR_IN == ars_pkg::OFS_INPUT_SELECT);
  wire hit_ctlb = (REG_ADDR_IN == ars_pkg::OFS_CONTROL_B);
  wire hit_status = (REG_ADDR_IN == ars_pkg::OFS_IRQ_STATUS);
  wire hit_mask = (REG_ADDR_IN == ars_pkg::OFS_IRQ_MASK);

  wire rd_low = REG_RD_IN & hit_low;
  wire rd_high = REG_RD_IN & hit_high;
  wire rd_status = REG_RD_IN & hit_status;
  wire wr_ctla = REG_WR_IN & hit_ctla;
  wire wr_mux = REG_WR_IN & hit_mux;
  wire wr_ctlb = REG_WR_IN & hit_ctlb;
  wire wr_mask = REG_WR_IN & hit_mask;

  // ==========================================================================
  // Result presentation
  // Purely combinational so the adjust bit acts even mid-conversion
  wire [ars_pkg::DATA_W-1:0] low_left = {
    result[ars_pkg::SPILL_W-1:0],
    {(ars_pkg::DATA_W - ars_pkg::SPILL_W){1'b0}}
  };
  wire [ars_pkg::DATA_W-1:0] high_left = result[ars_pkg::RESULT_W-1 -: ars_pkg::DATA_W];
  wire [ars_pkg::DATA_W-1:0] low_right = result[ars_pkg::DATA_W-1:0];
  wire [ars_pkg::DATA_W-1:0] high_right = {
    {(ars_pkg::DATA_W - ars_pkg::SPILL_W){1'b0}},
    result[ars_pkg::RESULT_W-1 -: ars_pkg::SPILL_W]
  };
  wire [ars_pkg::DATA_W-1:0] low_view = left_adjust_ctl ? low_left : low_right;
  wire [ars_pkg::DATA_W-1:0] high_view = left_adjust_ctl ? high_left : high_right;

  // ==========================================================================
  // Register views
  wire [ars_pkg::DATA_W-1:0] ctla_view = (ars_pkg::DATA_W'(converter_en) << ars_pkg::CTLA_EN_BIT)
                                       | (ars_pkg::DATA_W'(busy) << ars_pkg::CTLA_START_BIT)
                                       | (ars_pkg::DATA_W'(auto_trigger_en) << ars_pkg::CTLA_ATE_BIT)
                                       | (ars_pkg::DATA_W'(conversion_done_flag) << ars_pkg::CTLA_DONE_BIT);
  wire [ars_pkg::DATA_W-1:0] mux_view = ars_pkg::DATA_W'(left_adjust_ctl) << ars_pkg::MUX_LADJ_BIT;
  // Reserved bit 7 and bits 6:3 always read zero
  wire [ars_pkg::DATA_W-1:0] ctlb_view = ars_pkg::DATA_W'(trigger_source_sel) << ars_pkg::CTLB_SEL_LSB;
  wire [ars_pkg::DATA_W-1:0] status_view = ars_pkg::DATA_W'(irq_status);
  wire [ars_pkg::DATA_W-1:0] mask_view = ars_pkg::DATA_W'(irq_mask);

  // Unmapped offsets answer zero
  wire [ars_pkg::DATA_W-1:0] read_value = hit_low ? low_view :
                                          hit_high ? high_view :
                                          hit_ctla ? ctla_view :
                                          hit_mux ? mux_view :
                                          hit_ctlb ? ctlb_view :
                                          hit_status ? status_view :
                                          hit_mask ? mask_view :
                                          ars_pkg::RESET_BYTE;

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      rdata <= ars_pkg::RESET_BYTE;
    end else if (REG_RD_IN) begin
      rdata <= read_value;
    end else begin
      rdata <= ars_pkg::RESET_BYTE;
    end
  end

  assign REG_RDATA_OUT = rdata;

  // ==========================================================================
  // Read lock
  // A low read in the same cycle as completion already blocks that update
  wire update_ok = CONV_DONE_IN & (lock_state == ars_pkg::LOCK_OPEN) & ~rd_low;

  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      ars_pkg::LOCK_OPEN: begin
        if (rd_low) begin
          next_lock_state = ars_pkg::LOCK_HELD;
        end
      end
      ars_pkg::LOCK_HELD: begin
        // Only a high read closes an access; a low read never followed by one leaves the lock held
        if (rd_high) begin
          next_lock_state = ars_pkg::LOCK_OPEN;
        end
      end
      default: begin
        next_lock_state = ars_pkg::LOCK_OPEN;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      lock_state <= ars_pkg::LOCK_OPEN;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // ==========================================================================
  // Result store
  // Results finished while locked are lost, not queued
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      result <= ars_pkg::RESET_RESULT;
    end else if (update_ok) begin
      result <= CONV_RESULT_IN;
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      converter_en <= 1'b0;
      auto_trigger_en <= 1'b0;
    end else if (wr_ctla) begin
      converter_en <= REG_WDATA_IN[ars_pkg::CTLA_EN_BIT];
      auto_trigger_en <= REG_WDATA_IN[ars_pkg::CTLA_ATE_BIT];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      left_adjust_ctl <= 1'b0;
    end else if (wr_mux) begin
      left_adjust_ctl <= REG_WDATA_IN[ars_pkg::MUX_LADJ_BIT];
    end
  end

  // Bit 7 is not stored, whatever software writes there
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      trigger_source_sel <= ars_pkg::TRIG_FREE_RUN;
    end else if (wr_ctlb) begin
      trigger_source_sel <= REG_WDATA_IN[ars_pkg::CTLB_SEL_LSB +: ars_pkg::SEL_W];
    end
  end

  assign CONV_EN_OUT = converter_en;

  // ==========================================================================
  // Conversion done flag
  wire done_clear = wr_ctla & REG_WDATA_IN[ars_pkg::CTLA_DONE_BIT];

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      conversion_done_flag <= 1'b0;
    end else if (CONV_DONE_IN) begin
      conversion_done_flag <= 1'b1;
    end else if (done_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Trigger selection
  ars_trig #(
    .NUM_SRC(ars_pkg::NUM_SRC),
    .SEL_W(ars_pkg::SEL_W)
  ) u_trig (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .flags_in({TRIG_FLAGS_IN, conversion_done_flag}),
    .done_pulse_in(CONV_DONE_IN),
    .sel_in(trigger_source_sel),
    .auto_en_in(auto_trigger_en),
    .conv_en_in(converter_en),
    .trig_out(trig_hit)
  );

  // ==========================================================================
  // Conversion start
  // Start and enable may be written together
  wire soft_start = wr_ctla & REG_WDATA_IN[ars_pkg::CTLA_START_BIT] & REG_WDATA_IN[ars_pkg::CTLA_EN_BIT];
  // Edges while busy are dropped; the core takes one start at a time
  wire start_fire = (soft_start | trig_hit) & ~busy & ~conv_start;
  wire en_drop = wr_ctla & ~REG_WDATA_IN[ars_pkg::CTLA_EN_BIT];

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_fire & ~en_drop;
    end
  end

  // Disabling the converter aborts any conversion in flight
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      busy <= 1'b0;
    end else if (en_drop) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end else if (CONV_DONE_IN) begin
      busy <= 1'b0;
    end
  end

  assign CONV_START_OUT = conv_start;

  // ==========================================================================
  // Interrupts
  wire [ars_pkg::IRQ_W-1:0] irq_events = (ars_pkg::IRQ_W'(CONV_DONE_IN) << ars_pkg::IRQ_DONE_BIT)
                                       | (ars_pkg::IRQ_W'(conv_start) << ars_pkg::IRQ_TRIG_BIT);
  wire [ars_pkg::IRQ_W-1:0] irq_keep = rd_status ? ars_pkg::RESET_IRQ : irq_status;

  // Read clears, but an event in the reading cycle survives
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      irq_status <= ars_pkg::RESET_IRQ;
    end else begin
      irq_status <= irq_keep | irq_events;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      irq_mask <= ars_pkg::RESET_IRQ;
    end else if (wr_mask) begin
      irq_mask <= REG_WDATA_IN[ars_pkg::IRQ_W-1:0];
    end
  end

  assign IRQ_OUT = |(irq_status & irq_mask);

endmodule : ars_top

// >>> verification/ars_monitor.sv
module ars_monitor (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Register port
  input wire logic [ars_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [ars_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [ars_pkg::DATA_W-1:0] REG_RDATA_OUT,
  // Converter and interrupt
  input wire logic CONV_START_OUT,
  input wire logic CONV_EN_OUT,
  input wire logic IRQ_OUT
);
  logic ladj;
  wire rd_high = REG_RD_IN && REG_ADDR_IN == ars_pkg::OFS_RESULT_HIGH;
  wire rd_low = REG_RD_IN && REG_ADDR_IN == ars_pkg::OFS_RESULT_LOW;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // ==========================================================================
  // Shadow of the adjust control, needed to judge the padding
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      ladj <= 1'b0;
    end else if (REG_WR_IN && REG_ADDR_IN == ars_pkg::OFS_INPUT_SELECT) begin
      ladj <= REG_WDATA_IN[ars_pkg::MUX_LADJ_BIT];
    end
  end

  // ==========================================================================
  // Assertions
  a_rdata_idle_zero: assert property (
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data not zero outside read answer");
  a_start_one_cycle: assert property (
    CONV_START_OUT |=> !CONV_START_OUT)
    else $error("start longer than one cycle");
  a_start_needs_en: assert property (
    CONV_START_OUT |-> CONV_EN_OUT)
    else $error("start while converter disabled");
  a_enable_follows_write: assert property (
    REG_WR_IN && REG_ADDR_IN == ars_pkg::OFS_CONTROL_A |=> CONV_EN_OUT == $past(REG_WDATA_IN[ars_pkg::CTLA_EN_BIT]))
    else $error("enable does not follow write");
  a_ctlb_pad_zero: assert property (
    REG_RD_IN && REG_ADDR_IN == ars_pkg::OFS_CONTROL_B |=> REG_RDATA_OUT[7:3] == 5'h00)
    else $error("control b upper bits not zero");
  a_unmapped_zero: assert property (
    REG_RD_IN && REG_ADDR_IN > 4'h6 |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_high_pad_right: assert property (
    rd_high && !ladj |=> REG_RDATA_OUT[7:2] == 6'h00)
    else $error("right adjusted high byte padding wrong");
  a_low_pad_left: assert property (
    rd_low && ladj |=> REG_RDATA_OUT[5:0] == 6'h00)
    else $error("left adjusted low byte padding wrong");

  c_start: cover property (CONV_START_OUT);
  c_irq: cover property (IRQ_OUT);
  c_high_left: cover property (rd_high && ladj);
endmodule : ars_monitor

bind ars_top ars_monitor mon_u (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .CONV_START_OUT(CONV_START_OUT), .CONV_EN_OUT(CONV_EN_OUT), .IRQ_OUT(IRQ_OUT));

// >>> verification/ars_top_tb.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ars_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, resetn_in = 1'b0, wr = 1'b0, rd = 1'b0, done = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, d;
  logic [9:0] result = 10'h000, r1, r2;
  logic [7:1] flags = 7'h00;
  logic [7:0] rdata;
  logic start, en, irq, ladj;
  int miscompares = 0, n_checks = 0, seed = 36565;

  ars_top dut_u (.CLK_IN(clk_in), .RESETN_IN(resetn_in), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CONV_DONE_IN(done), .CONV_RESULT_IN(result),
    .CONV_START_OUT(start), .CONV_EN_OUT(en), .TRIG_FLAGS_IN(flags), .IRQ_OUT(irq));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Expectations and bus cycles
  function automatic logic [7:0] exp_low(logic [9:0] r, logic la);
    return la ? {r[1:0], 6'h00} : r[7:0];
  endfunction : exp_low
  function automatic logic [7:0] exp_high(logic [9:0] r, logic la);
    return la ? r[9:2] : {6'h00, r[9:8]};
  endfunction : exp_high
  task automatic wr_reg(logic [3:0] a, logic [7:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rd_chk(logic [3:0] a, logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    `CHK(v, e)
  endtask : rd_chk
  task automatic conv(logic [9:0] r);
    @(posedge clk_in);
    done <= 1'b1;
    result <= r;
    @(posedge clk_in);
    done <= 1'b0;
  endtask : conv
  task automatic exp_start(logic e);
    @(posedge clk_in);
    #1 `CHK(start, e)
  endtask : exp_start
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Guard against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    end_sim;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk(ars_pkg::OFS_RESULT_LOW, 8'h00);
    rd_chk(ars_pkg::OFS_RESULT_HIGH, 8'h00);
    rd_chk(4'hf, 8'h00);
    for (int i = 0; i < 24; i++) begin
      r1 = (i == 0) ? 10'h3ff : 10'($random(seed));
      ladj = 1'($random(seed));
      wr_reg(ars_pkg::OFS_INPUT_SELECT, {2'b00, ladj, 5'h00});
      conv(r1);
      rd_chk(ars_pkg::OFS_RESULT_LOW, exp_low(r1, ladj));
      rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r1, ladj));
      wr_reg(ars_pkg::OFS_INPUT_SELECT, {2'b00, !ladj, 5'h00});
      rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r1, !ladj));
    end
    // Low read freezes the pair; a completion meanwhile is lost
    wr_reg(ars_pkg::OFS_INPUT_SELECT, 8'h00);
    r1 = 10'h2a5;
    r2 = 10'h15a;
    conv(r1);
    rd_chk(ars_pkg::OFS_RESULT_LOW, exp_low(r1, 1'b0));
    conv(r2);
    rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r1, 1'b0));
    conv(r2);
    rd_chk(ars_pkg::OFS_RESULT_LOW, exp_low(r2, 1'b0));
    rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r2, 1'b0));
    wr_reg(ars_pkg::OFS_INPUT_SELECT, 8'h20);
    conv(r1);
    rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r1, 1'b1));
    conv(r2);
    rd_chk(ars_pkg::OFS_RESULT_HIGH, exp_high(r2, 1'b1));
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h7f);
    rd_chk(ars_pkg::OFS_CONTROL_B, 8'h07);
    // Interrupt: raise, clear by read, then mask
    rd_reg(ars_pkg::OFS_IRQ_STATUS, d);
    wr_reg(ars_pkg::OFS_IRQ_MASK, 8'h01);
    conv(r1);
    #1 `CHK(irq, 1'b1)
    rd_chk(ars_pkg::OFS_CONTROL_A, 8'h10);
    rd_chk(ars_pkg::OFS_IRQ_STATUS, 8'h01);
    `CHK(irq, 1'b0)
    wr_reg(ars_pkg::OFS_IRQ_MASK, 8'h00);
    conv(r2);
    #1 `CHK(irq, 1'b0)
    // Every peripheral trigger source code, 1 to 7
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'ha0);
    #1 `CHK(en, 1'b1)
    for (int s = 1; s < 8; s++) begin
      wr_reg(ars_pkg::OFS_CONTROL_B, 8'(s));
      @(posedge clk_in);
      flags[s] <= 1'b1;
      exp_start(1'b1);
      exp_start(1'b0);
      conv(r1);
      flags <= 7'h00;
    end
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'h80);
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h03);
    @(posedge clk_in);
    flags <= 7'h04;
    exp_start(1'b0);
    exp_start(1'b0);
    // Switching to a set source: refused while disabled, then a start
    @(posedge clk_in);
    flags <= 7'h10;
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'h20);
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h05);
    exp_start(1'b0);
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h03);
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'ha0);
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h05);
    exp_start(1'b1);
    conv(r2);
    // Leave for a clear source first, so a level-based switch would fire
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h03);
    wr_reg(ars_pkg::OFS_CONTROL_B, 8'h00);
    exp_start(1'b0);
    exp_start(1'b0);
    // Free running restarts on a completion while not busy
    conv(r1);
    #1 `CHK(start, 1'b1)
    rd_chk(ars_pkg::OFS_CONTROL_A, 8'hf0);
    rd_chk(ars_pkg::OFS_IRQ_STATUS, 8'h03);
    rd_chk(ars_pkg::OFS_IRQ_STATUS, 8'h00);
    // Clearing enable aborts; writing one clears the done flag
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'h10);
    rd_chk(ars_pkg::OFS_CONTROL_A, 8'h00);
    wr_reg(ars_pkg::OFS_CONTROL_A, 8'hc0);
    #1 `CHK(start, 1'b1)
    `CHK(en, 1'b1)
    end_sim;
  end
endmodule : ars_top_tb
